// ===== rtl/serial_port_pkg.sv
package serial_port_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int ADDR_W = 3;
  localparam logic [2:0] CTRL_ONE_ADDR = 3'h0;
  localparam logic [2:0] CTRL_TWO_ADDR = 3'h1;
  localparam logic [2:0] STATUS_ONE_ADDR = 3'h2;
  localparam logic [2:0] DATA_ADDR = 3'h3;
  localparam logic [2:0] CTRL_THREE_ADDR = 3'h4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // control one fields
  localparam int LOOP_BIT = 7;
  localparam int RX_SOURCE_SEL_BIT = 5;
  localparam int NINE_BIT = 4;
  localparam int WAKE_BIT = 3;
  // control two fields
  localparam int XMIT_EMPTY_IE_BIT = 7;
  localparam int XMIT_DONE_IE_BIT = 6;
  localparam int RX_FULL_IE_BIT = 5;
  localparam int QUIET_IE_BIT = 4;
  localparam int XMIT_ON_BIT = 3;
  localparam int RX_ON_BIT = 2;
  localparam int STANDBY_BIT = 1;
  localparam int BREAK_BIT = 0;
  // control three fields
  localparam int RX_BIT8_BIT = 7;
  localparam int TX_BIT8_BIT = 6;
  localparam int DIR_BIT = 5;
  localparam int LONG_BREAK_BIT = 2;
  // status one fields
  localparam int XMIT_BUF_EMPTY_BIT = 7;
  localparam int TC_BIT = 6;
  localparam int RX_BUF_FULL_BIT = 5;
  localparam int IDLE_BIT = 4;
  localparam int OVERRUN_BIT = 3;
  localparam int FRAMING_BIT = 1;
  // ----------------------------------------
  // framing and timing
  // ----------------------------------------
  localparam logic [3:0] FRAME_BITS_8 = 4'ha;
  localparam logic [3:0] FRAME_BITS_9 = 4'hb;
  localparam logic [3:0] LONG_BREAK_EXTRA = 4'h3;
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;
  localparam logic [3:0] SUB_LAST = 4'hf;
  localparam logic [3:0] SUB_HALF = 4'h7;
  localparam int CLK_HZ = 125000000;
  localparam int BAUD_RATE = 115200;
  localparam int OVERSAMPLE = 16;
  localparam int TICK_CYCLES = CLK_HZ / (BAUD_RATE * OVERSAMPLE);

  function automatic logic [3:0] frame_len(input logic nine);
    frame_len = nine ? FRAME_BITS_9 : FRAME_BITS_8;
  endfunction : frame_len
endpackage : serial_port_pkg

// ===== rtl/serial_link_if.sv
`timescale 1ns/1ns
interface serial_link_if;
  logic dev_tx_out;
  logic dev_tx_oe;
  logic dev_rx_pin_used;
  logic node_rxd_out;
  logic node_line_out;
  logic node_line_oe;
  logic tx_line;
  logic rxd_line;

  // ----------------------------------------
  // wire resolution, pulled high when undriven
  // ----------------------------------------
  assign tx_line = dev_tx_oe ? dev_tx_out : (node_line_oe ? node_line_out : 1'b1);
  assign rxd_line = node_rxd_out;

  modport device (output dev_tx_out, output dev_tx_oe, output dev_rx_pin_used, input tx_line, input rxd_line);
  modport node (output node_rxd_out, output node_line_out, output node_line_oe, input tx_line);
endinterface : serial_link_if

// ===== rtl/serial_port_device.sv
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
// Overview of operation
// - transmit-empty interrupt enabled by control bit 7
// - transmit-done interrupt enabled by control bit 6
// - receive-full interrupt enabled by control bit 5
// - idle-line interrupt enabled by control bit 4
// - bit 3 enables transmitter, owns output pin
// - single-wire mode: direction bit picks pin direction
// - enable toggled off-on queues one idle character
// - pin held until pending traffic finishes
// - bit 2 enables receiver, else pin released
// - loop mode releases input pin
// - bit 1 puts receiver in standby
// - wakeup by idle line or address mark
// - hardware clears standby on wakeup
// - break bit written 1 then 0 queues break
// - break bit held queues more breaks, length selectable
// - second break may be queued
// - control two accessible at any time
// - status register read-only, writes ignored
// - flags cleared by read-then-access sequences
// - empty flag set at reset and on load
// - done flag reflects idle transmitter
module serial_port_device #(
  parameter int TICK_DIV = serial_port_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic xmit_empty_irq,
  output logic xmit_done_irq,
  output logic rx_full_irq,
  output logic line_quiet_irq,
  serial_link_if.device link
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

  logic [7:0] ctrl1_r, ctrl2_r, ctrl3_r, armed_r, rdata_r, status_val;
  logic rx_standby_r, rx_bit8_r;
  logic xmit_buf_empty_r, pre_pend_r, brk_pend_r, tx_busy_r;
  logic [13:0] tx_shift_r;
  logic [3:0] tx_left_r, tx_sub_r;
  logic [8:0] tx_buf_r;
  logic [15:0] div_r;
  logic tick, brk_go, load, tc, tx_out, tx_own, single;
  logic wr_c1, wr_c2, wr_c3, wr_dat, rd_stat, rd_dat;
  logic [2:0] rxd_s_r, line_s_r;
  logic rxd_r, line_r, rx_in;
  rx_state_t rx_state_r;
  logic [3:0] rx_sub_r, rx_bit_r, idle_cnt_r, fb;
  logic [8:0] rx_shift_r, rx_data_r, rx_word;
  logic rx_buf_full_r, idle_r, over_r, fe_r, idle_arm_r, active_r;
  logic char_done, accept, wake_hit, quiet_hit, msb;

  assign wr_c1 = reg_wr && reg_addr == serial_port_pkg::CTRL_ONE_ADDR;
  assign wr_c2 = reg_wr && reg_addr == serial_port_pkg::CTRL_TWO_ADDR;
  assign wr_c3 = reg_wr && reg_addr == serial_port_pkg::CTRL_THREE_ADDR;
  assign wr_dat = reg_wr && reg_addr == serial_port_pkg::DATA_ADDR;
  assign rd_stat = reg_rd && reg_addr == serial_port_pkg::STATUS_ONE_ADDR;
  assign rd_dat = reg_rd && reg_addr == serial_port_pkg::DATA_ADDR;
  assign fb = serial_port_pkg::frame_len(ctrl1_r[serial_port_pkg::NINE_BIT]);

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl1_r <= serial_port_pkg::CTRL_RESET;
      ctrl3_r <= serial_port_pkg::CTRL_RESET;
    end
    else
    begin
      if (wr_c1)
        ctrl1_r <= reg_wdata;
      if (wr_c3)
        ctrl3_r <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl2_r <= serial_port_pkg::CTRL_RESET;
      rx_standby_r <= 1'b0;
    end
    else
    begin
      if (wake_hit)
        rx_standby_r <= 1'b0;
      if (wr_c2)
      begin
        ctrl2_r <= reg_wdata;
        rx_standby_r <= reg_wdata[serial_port_pkg::STANDBY_BIT];
      end
    end
  end

  // ----------------------------------------
  // status snapshot for clear sequences
  // ----------------------------------------
  assign tc = xmit_buf_empty_r && !tx_busy_r && !pre_pend_r && !brk_go;
  assign status_val = {xmit_buf_empty_r, tc, rx_buf_full_r, idle_r, over_r, 1'b0, fe_r, 1'b0};

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      armed_r <= 8'h00;
    else if (rd_stat)
      armed_r <= status_val;
    else if (wr_dat || rd_dat)
      armed_r <= 8'h00;
  end

  // ----------------------------------------
  // register read port, status not writable
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_r <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        serial_port_pkg::CTRL_ONE_ADDR: rdata_r <= ctrl1_r;
        serial_port_pkg::CTRL_TWO_ADDR: rdata_r <= {ctrl2_r[7:2], rx_standby_r, ctrl2_r[0]};
        serial_port_pkg::STATUS_ONE_ADDR: rdata_r <= status_val;
        serial_port_pkg::DATA_ADDR: rdata_r <= rx_data_r[7:0];
        serial_port_pkg::CTRL_THREE_ADDR: rdata_r <= {rx_bit8_r, ctrl3_r[6:0]};
        default: rdata_r <= 8'h00;
      endcase
    end
  end
  assign reg_rdata = rdata_r;

  // ----------------------------------------
  // oversample tick divider
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      div_r <= 16'h0000;
    else if (tick)
      div_r <= 16'h0000;
    else
      div_r <= div_r + 16'h0001;
  end
  assign tick = div_r == 16'(TICK_DIV - 1);

  // ----------------------------------------
  // transmit queue
  // ----------------------------------------
  assign brk_go = brk_pend_r || ctrl2_r[serial_port_pkg::BREAK_BIT];
  assign load = !tx_busy_r && (brk_go || pre_pend_r || !xmit_buf_empty_r);

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pre_pend_r <= 1'b0;
      brk_pend_r <= 1'b0;
      xmit_buf_empty_r <= 1'b1;
      tx_buf_r <= 9'h000;
    end
    else
    begin
      if (load && !brk_go)
        pre_pend_r <= 1'b0;
      if (wr_c2 && reg_wdata[serial_port_pkg::XMIT_ON_BIT] && !ctrl2_r[serial_port_pkg::XMIT_ON_BIT])
        pre_pend_r <= 1'b1;
      if (load && brk_go)
        brk_pend_r <= 1'b0;
      if (wr_c2 && reg_wdata[serial_port_pkg::BREAK_BIT] && !ctrl2_r[serial_port_pkg::BREAK_BIT])
        brk_pend_r <= 1'b1;
      if (wr_dat)
        tx_buf_r <= {ctrl3_r[serial_port_pkg::TX_BIT8_BIT], reg_wdata};
      if (wr_dat && armed_r[serial_port_pkg::XMIT_BUF_EMPTY_BIT])
        xmit_buf_empty_r <= 1'b0;
      if (load && !brk_go && !pre_pend_r)
        xmit_buf_empty_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // transmit shifter
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_busy_r <= 1'b0;
      tx_shift_r <= 14'h3fff;
      tx_left_r <= 4'h0;
      tx_sub_r <= 4'h0;
    end
    else if (load)
    begin
      tx_busy_r <= 1'b1;
      tx_sub_r <= 4'h0;
      if (brk_go)
      begin
        tx_shift_r <= 14'h0000;
        tx_left_r <= ctrl3_r[serial_port_pkg::LONG_BREAK_BIT] ? fb + serial_port_pkg::LONG_BREAK_EXTRA : fb;
      end
      else
      begin
        tx_left_r <= fb;
        if (pre_pend_r)
          tx_shift_r <= 14'h3fff;
        else
          tx_shift_r <= {4'hf, ctrl1_r[serial_port_pkg::NINE_BIT] ? tx_buf_r[8] : 1'b1, tx_buf_r[7:0], 1'b0};
      end
    end
    else if (tx_busy_r && tick)
    begin
      if (tx_sub_r == serial_port_pkg::SUB_LAST)
      begin
        tx_sub_r <= 4'h0;
        tx_shift_r <= {1'b1, tx_shift_r[13:1]};
        tx_left_r <= tx_left_r - 4'h1;
        if (tx_left_r == 4'h1)
          tx_busy_r <= 1'b0;
      end
      else
        tx_sub_r <= tx_sub_r + 4'h1;
    end
  end

  // ----------------------------------------
  // pin ownership
  // ----------------------------------------
  assign tx_out = tx_busy_r ? tx_shift_r[0] : 1'b1;
  assign single = ctrl1_r[serial_port_pkg::LOOP_BIT] && ctrl1_r[serial_port_pkg::RX_SOURCE_SEL_BIT];
  assign tx_own = ctrl2_r[serial_port_pkg::XMIT_ON_BIT] || tx_busy_r || load || pre_pend_r;
  assign link.dev_tx_out = tx_out;
  assign link.dev_tx_oe = tx_own && (!single || ctrl3_r[serial_port_pkg::DIR_BIT]);
  assign link.dev_rx_pin_used = ctrl2_r[serial_port_pkg::RX_ON_BIT] && !ctrl1_r[serial_port_pkg::LOOP_BIT];

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rxd_s_r <= 3'h7;
      line_s_r <= 3'h7;
      rxd_r <= 1'b1;
      line_r <= 1'b1;
    end
    else
    begin
      rxd_s_r <= {rxd_s_r[1:0], link.rxd_line};
      line_s_r <= {line_s_r[1:0], link.tx_line};
      if (rxd_s_r[1] == rxd_s_r[2])
        rxd_r <= rxd_s_r[2];
      if (line_s_r[1] == line_s_r[2])
        line_r <= line_s_r[2];
    end
  end
  assign rx_in = ctrl1_r[serial_port_pkg::LOOP_BIT] ? (ctrl1_r[serial_port_pkg::RX_SOURCE_SEL_BIT] ? line_r : tx_out) : rxd_r;

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  assign char_done = rx_state_r == RX_STOP && tick && rx_sub_r == serial_port_pkg::SUB_LAST;
  assign rx_word = ctrl1_r[serial_port_pkg::NINE_BIT] ? rx_shift_r : {1'b0, rx_shift_r[8:1]};
  assign msb = ctrl1_r[serial_port_pkg::NINE_BIT] ? rx_word[8] : rx_word[7];
  assign quiet_hit = rx_state_r == RX_IDLE && tick && rx_sub_r == serial_port_pkg::SUB_LAST
    && active_r && idle_cnt_r + 4'h1 == fb && ctrl2_r[serial_port_pkg::RX_ON_BIT];
  assign wake_hit = rx_standby_r && (ctrl1_r[serial_port_pkg::WAKE_BIT] ? char_done && msb : quiet_hit);
  assign accept = char_done && (!rx_standby_r || wake_hit);

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_state_r <= RX_IDLE;
      rx_sub_r <= 4'h0;
      rx_bit_r <= 4'h0;
      rx_shift_r <= 9'h000;
      idle_cnt_r <= 4'h0;
      active_r <= 1'b0;
    end
    else if (!ctrl2_r[serial_port_pkg::RX_ON_BIT])
      rx_state_r <= RX_IDLE;
    else
    begin
      case (rx_state_r)
        RX_IDLE:
        begin
          if (!rx_in)
          begin
            rx_state_r <= RX_START;
            rx_sub_r <= 4'h0;
            idle_cnt_r <= 4'h0;
            active_r <= 1'b1;
          end
          else if (tick)
          begin
            rx_sub_r <= rx_sub_r + 4'h1;
            if (rx_sub_r == serial_port_pkg::SUB_LAST && idle_cnt_r != fb)
              idle_cnt_r <= idle_cnt_r + 4'h1;
            if (quiet_hit)
              active_r <= 1'b0;
          end
        end
        RX_START:
        begin
          if (tick)
          begin
            rx_sub_r <= rx_sub_r + 4'h1;
            if (rx_sub_r == serial_port_pkg::SUB_HALF)
            begin
              rx_sub_r <= 4'h0;
              rx_bit_r <= 4'h0;
              rx_state_r <= rx_in ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA:
        begin
          if (tick)
          begin
            rx_sub_r <= rx_sub_r + 4'h1;
            if (rx_sub_r == serial_port_pkg::SUB_LAST)
            begin
              rx_shift_r <= {rx_in, rx_shift_r[8:1]};
              rx_bit_r <= rx_bit_r + 4'h1;
              if (rx_bit_r + 4'h1 == (ctrl1_r[serial_port_pkg::NINE_BIT]
                  ? serial_port_pkg::DATA_BITS_9 : serial_port_pkg::DATA_BITS_8))
                rx_state_r <= RX_STOP;
            end
          end
        end
        RX_STOP:
        begin
          if (tick)
          begin
            rx_sub_r <= rx_sub_r + 4'h1;
            if (char_done)
              rx_state_r <= RX_IDLE;
          end
        end
        default: rx_state_r <= RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // receive flags, set wins over clear
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_buf_full_r <= 1'b0;
      idle_r <= 1'b0;
      over_r <= 1'b0;
      fe_r <= 1'b0;
      idle_arm_r <= 1'b0;
      rx_data_r <= 9'h000;
      rx_bit8_r <= 1'b0;
    end
    else
    begin
      if (rd_dat)
      begin
        if (armed_r[serial_port_pkg::RX_BUF_FULL_BIT])
          rx_buf_full_r <= 1'b0;
        if (armed_r[serial_port_pkg::IDLE_BIT])
          idle_r <= 1'b0;
        if (armed_r[serial_port_pkg::OVERRUN_BIT])
          over_r <= 1'b0;
        if (armed_r[serial_port_pkg::FRAMING_BIT])
          fe_r <= 1'b0;
      end
      if (quiet_hit && idle_arm_r)
      begin
        idle_r <= 1'b1;
        idle_arm_r <= 1'b0;
      end
      if (accept && rx_buf_full_r && !(rd_dat && armed_r[serial_port_pkg::RX_BUF_FULL_BIT]))
        over_r <= 1'b1;
      else if (accept)
      begin
        rx_buf_full_r <= 1'b1;
        idle_arm_r <= 1'b1;
        rx_data_r <= rx_word;
        rx_bit8_r <= rx_word[8];
        fe_r <= !rx_in;
      end
    end
  end

  // ----------------------------------------
  // interrupt requests
  // ----------------------------------------
  assign xmit_empty_irq = xmit_buf_empty_r && ctrl2_r[serial_port_pkg::XMIT_EMPTY_IE_BIT];
  assign xmit_done_irq = tc && ctrl2_r[serial_port_pkg::XMIT_DONE_IE_BIT];
  assign rx_full_irq = rx_buf_full_r && ctrl2_r[serial_port_pkg::RX_FULL_IE_BIT];
  assign line_quiet_irq = idle_r && ctrl2_r[serial_port_pkg::QUIET_IE_BIT];
endmodule : serial_port_device

// ===== rtl/serial_node.sv
`timescale 1ns/1ns
module serial_node #(
  parameter int TICK_DIV = serial_port_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic send_valid,
  input wire logic [7:0] send_data,
  output logic send_ready,
  input wire logic drive_shared,
  output logic recv_valid,
  output logic [7:0] recv_data,
  output logic recv_break,
  serial_link_if.node link
);
  logic [15:0] div_r;
  logic tick, busy_r, rx_busy_r, rx_r;
  logic [9:0] shift_r, rx_shift_r;
  logic [3:0] left_r, sub_r, rx_sub_r, rx_left_r;
  logic [2:0] sync_r;

  // ----------------------------------------
  // tick divider
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      div_r <= 16'h0000;
    else if (tick)
      div_r <= 16'h0000;
    else
      div_r <= div_r + 16'h0001;
  end
  assign tick = div_r == 16'(TICK_DIV - 1);

  // ----------------------------------------
  // transmitter, 8 data bits
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy_r <= 1'b0;
      shift_r <= 10'h3ff;
      left_r <= 4'h0;
      sub_r <= 4'h0;
    end
    else if (send_valid && !busy_r)
    begin
      busy_r <= 1'b1;
      shift_r <= {1'b1, send_data, 1'b0};
      left_r <= serial_port_pkg::FRAME_BITS_8;
      sub_r <= 4'h0;
    end
    else if (busy_r && tick)
    begin
      sub_r <= sub_r + 4'h1;
      if (sub_r == serial_port_pkg::SUB_LAST)
      begin
        shift_r <= {1'b1, shift_r[9:1]};
        left_r <= left_r - 4'h1;
        if (left_r == 4'h1)
          busy_r <= 1'b0;
      end
    end
  end
  assign send_ready = !busy_r;
  assign link.node_rxd_out = drive_shared ? 1'b1 : shift_r[0];
  assign link.node_line_out = shift_r[0];
  assign link.node_line_oe = drive_shared;

  // ----------------------------------------
  // receiver on the device's output line
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync_r <= 3'h7;
      rx_r <= 1'b1;
    end
    else
    begin
      sync_r <= {sync_r[1:0], link.tx_line};
      if (sync_r[1] == sync_r[2])
        rx_r <= sync_r[2];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_busy_r <= 1'b0;
      rx_shift_r <= 10'h000;
      rx_sub_r <= 4'h0;
      rx_left_r <= 4'h0;
      recv_valid <= 1'b0;
      recv_break <= 1'b0;
      recv_data <= 8'h00;
    end
    else
    begin
      recv_valid <= 1'b0;
      recv_break <= 1'b0;
      if (!rx_busy_r && !rx_r && !drive_shared)
      begin
        rx_busy_r <= 1'b1;
        rx_sub_r <= 4'h0;
        rx_left_r <= serial_port_pkg::FRAME_BITS_8;
      end
      else if (rx_busy_r && tick)
      begin
        rx_sub_r <= rx_sub_r + 4'h1;
        if (rx_sub_r == serial_port_pkg::SUB_HALF)
        begin
          rx_shift_r <= {rx_r, rx_shift_r[9:1]};
          rx_left_r <= rx_left_r - 4'h1;
          if (rx_left_r == 4'h1)
          begin
            rx_busy_r <= 1'b0;
            if (rx_r)
            begin
              recv_valid <= 1'b1;
              recv_data <= rx_shift_r[9:2];
            end
            else
              recv_break <= 1'b1;
          end
        end
      end
    end
  end
endmodule : serial_node

// ===== bench/uart_control_enables_sva.sv
`timescale 1ns/1ns
module uart_control_enables_sva (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic xmit_empty_irq,
  input wire logic xmit_done_irq,
  input wire logic rx_full_irq,
  input wire logic line_quiet_irq,
  input wire logic dev_tx_out,
  input wire logic dev_tx_oe,
  input wire logic dev_rx_pin_used
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic ctl_wr;
  logic one_wire_r;
  assign ctl_wr = reg_wr && reg_addr == serial_port_pkg::CTRL_TWO_ADDR;
  // single-wire mode, where the direction bit may keep the pin released
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      one_wire_r <= 1'b0;
    else if (reg_wr && reg_addr == serial_port_pkg::CTRL_ONE_ADDR)
      one_wire_r <= reg_wdata[serial_port_pkg::LOOP_BIT] && reg_wdata[serial_port_pkg::RX_SOURCE_SEL_BIT];
  end
  // ----------------------------------------
  // control two effects
  // ----------------------------------------
  a_empty_irq_off: assert property (ctl_wr && !reg_wdata[7] |=> !xmit_empty_irq)
    else $error("empty request while disabled");
  a_done_irq_off: assert property (ctl_wr && !reg_wdata[6] |=> !xmit_done_irq)
    else $error("done request while disabled");
  a_rx_irq_off: assert property (ctl_wr && !reg_wdata[5] |=> !rx_full_irq)
    else $error("rx request while disabled");
  a_quiet_irq_off: assert property (ctl_wr && !reg_wdata[4] |=> !line_quiet_irq)
    else $error("idle request while disabled");
  a_xmit_on_drives: assert property (ctl_wr && reg_wdata[3] && !one_wire_r |-> ##[1:2] dev_tx_oe)
    else $error("transmitter on but pin not driven");
  a_rx_off_free: assert property (ctl_wr && !reg_wdata[2] |-> ##[1:2] !dev_rx_pin_used)
    else $error("receiver off but pin kept");
  a_low_is_owned: assert property (!dev_tx_out |-> dev_tx_oe)
    else $error("line low while pin released");
  a_release_idle: assert property ($fell(dev_tx_oe) |-> $past(dev_tx_out))
    else $error("pin released mid character");
  c_tx_owned: cover property ($rose(dev_tx_oe));
  c_tx_frame: cover property ($fell(dev_tx_out));
  c_rx_used: cover property ($rose(dev_rx_pin_used));
endmodule : uart_control_enables_sva

// ===== bench/uart_control_enables_tb_top.sv
`timescale 1ns/1ns
module uart_control_enables_tb_top;
  logic ref_clk;
  logic rst_b;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic [3:0] irq;
  logic send_valid;
  logic [7:0] send_data;
  logic send_ready;
  logic recv_valid;
  logic [7:0] recv_data;
  logic recv_break;
  logic [7:0] v;
  logic [7:0] rows [5][2];
  int errors;
  int checks;
  serial_link_if link_if ();
  serial_port_device #(.TICK_DIV(2)) serial_port_device_inst (.ref_clk, .rst_b, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .xmit_empty_irq(irq[3]), .xmit_done_irq(irq[2]), .rx_full_irq(irq[1]),
    .line_quiet_irq(irq[0]), .link(link_if));
  serial_node #(.TICK_DIV(2)) serial_node_inst (.ref_clk, .rst_b, .send_valid, .send_data, .send_ready,
    .drive_shared(1'b0), .recv_valid, .recv_data, .recv_break, .link(link_if));
  uart_control_enables_sva uart_control_enables_sva_inst (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
    .xmit_empty_irq(irq[3]), .xmit_done_irq(irq[2]), .rx_full_irq(irq[1]), .line_quiet_irq(irq[0]),
    .dev_tx_out(link_if.dev_tx_out), .dev_tx_oe(link_if.dev_tx_oe), .dev_rx_pin_used(link_if.dev_rx_pin_used));
  // ----------------------------------------
  // bench tasks
  // ----------------------------------------
  task report_and_stop;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(negedge ref_clk);
  endtask : wr
  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask : rd
  function automatic logic pick(input int sel);
    case (sel)
      0: pick = recv_valid;
      1: pick = recv_break;
      2: pick = link_if.dev_tx_oe;
      default: pick = send_ready;
    endcase
  endfunction : pick
  task wait_sig(input int sel, input logic lvl);
    int n;
    n = 0;
    while (pick(sel) !== lvl && n < 5000)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 5000)
    begin
      errors++;
      $display("mismatch wait %0d expected %h seen %h", sel, lvl, ~lvl);
      report_and_stop();
    end
  endtask : wait_sig
  task send_byte(input logic [7:0] b);
    @(posedge ref_clk);
    send_valid <= 1'b1;
    send_data <= b;
    @(negedge ref_clk);
    wait_sig(3, 1'b0);
    @(posedge ref_clk);
    send_valid <= 1'b0;
    @(negedge ref_clk);
    wait_sig(3, 1'b1);
    repeat (40) @(negedge ref_clk);
  endtask : send_byte
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    errors = 0;
    checks = 0;
    rst_b = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    send_valid = 1'b0;
    send_data = 8'h00;
    rows = '{'{8'h80, 8'h08}, '{8'h40, 8'h04}, '{8'hc0, 8'h0c}, '{8'h30, 8'h00}, '{8'h00, 8'h00}};
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(serial_port_pkg::STATUS_ONE_ADDR, v);
    chk("status", v, 8'hc0);
    for (int i = 0; i < 5; i++)
    begin
      wr(serial_port_pkg::CTRL_TWO_ADDR, rows[i][0]);
      chk("irq", {4'h0, irq}, rows[i][1]);
      rd(serial_port_pkg::CTRL_TWO_ADDR, v);
      chk("ctrl2", v, rows[i][0]);
    end
    wr(serial_port_pkg::STATUS_ONE_ADDR, 8'h00);
    rd(serial_port_pkg::STATUS_ONE_ADDR, v);
    chk("status", v, 8'hc0);
    wr(serial_port_pkg::CTRL_TWO_ADDR, 8'h2c);
    rd(serial_port_pkg::STATUS_ONE_ADDR, v);
    wr(serial_port_pkg::DATA_ADDR, 8'ha5);
    rd(serial_port_pkg::STATUS_ONE_ADDR, v);
    chk("done", v & 8'h40, 8'h00);
    wait_sig(0, 1'b1);
    chk("tx byte", recv_data, 8'ha5);
    send_byte(8'h3c);
    chk("rx irq", {7'h0, irq[1]}, 8'h01);
    rd(serial_port_pkg::STATUS_ONE_ADDR, v);
    rd(serial_port_pkg::DATA_ADDR, v);
    chk("rx byte", v, 8'h3c);
    chk("rx irq", {7'h0, irq[1]}, 8'h00);
    wr(serial_port_pkg::CTRL_ONE_ADDR, 8'h08);
    wr(serial_port_pkg::CTRL_TWO_ADDR, 8'h06);
    send_byte(8'h01);
    rd(serial_port_pkg::STATUS_ONE_ADDR, v);
    chk("standby", v & 8'h20, 8'h00);
    send_byte(8'h81);
    rd(serial_port_pkg::CTRL_TWO_ADDR, v);
    chk("wake", v, 8'h04);
    rd(serial_port_pkg::DATA_ADDR, v);
    chk("mark byte", v, 8'h81);
    wr(serial_port_pkg::CTRL_ONE_ADDR, 8'h00);
    wr(serial_port_pkg::CTRL_TWO_ADDR, 8'h16);
    send_byte(8'h11);
    repeat (400) @(negedge ref_clk);
    rd(serial_port_pkg::CTRL_TWO_ADDR, v);
    chk("quiet wake", v, 8'h14);
    chk("quiet irq", {7'h0, irq[0]}, 8'h01);
    wr(serial_port_pkg::CTRL_TWO_ADDR, 8'h0d);
    rd(serial_port_pkg::STATUS_ONE_ADDR, v);
    chk("done", v & 8'h40, 8'h00);
    wr(serial_port_pkg::CTRL_TWO_ADDR, 8'h0c);
    wait_sig(1, 1'b1);
    chk("break", {7'h0, recv_break}, 8'h01);
    rd(serial_port_pkg::STATUS_ONE_ADDR, v);
    wr(serial_port_pkg::DATA_ADDR, 8'h55);
    wr(serial_port_pkg::CTRL_TWO_ADDR, 8'h00);
    chk("tx owned", {7'h0, link_if.dev_tx_oe}, 8'h01);
    wait_sig(2, 1'b0);
    chk("last byte", recv_data, 8'h55);
    wr(serial_port_pkg::CTRL_TWO_ADDR, 8'h08);
    chk("rx pin", {7'h0, link_if.dev_rx_pin_used}, 8'h00);
    wr(serial_port_pkg::CTRL_TWO_ADDR, 8'h04);
    chk("rx pin", {7'h0, link_if.dev_rx_pin_used}, 8'h01);
    wr(serial_port_pkg::CTRL_ONE_ADDR, 8'h80);
    chk("rx pin", {7'h0, link_if.dev_rx_pin_used}, 8'h00);
    wr(serial_port_pkg::CTRL_ONE_ADDR, 8'ha0);
    wr(serial_port_pkg::CTRL_THREE_ADDR, 8'h20);
    wr(serial_port_pkg::CTRL_TWO_ADDR, 8'h08);
    chk("one wire", {7'h0, link_if.dev_tx_oe}, 8'h01);
    wr(serial_port_pkg::CTRL_THREE_ADDR, 8'h00);
    chk("one wire", {7'h0, link_if.dev_tx_oe}, 8'h00);
    report_and_stop();
  end
endmodule : uart_control_enables_tb_top
